/* File: inc/dte_cfg.svh */
`ifndef DTE_CFG_SVH
`define DTE_CFG_SVH

// Channel and word geometry
`define DTE_NUM_CH 5
`define DTE_CODE_W 16
`define DTE_WORD_W 32
`define DTE_SHORT_W 24
`define DTE_FLAG_W 8
`define DTE_CNT_W 16

// Command codes, bits 23:20 of a 32-bit word
`define DTE_CMD_WRITE_A_OR_B 4'h0
`define DTE_CMD_WRITE_UPD 4'h3
`define DTE_CMD_UPDATE_ALL 4'h9
`define DTE_CMD_WRITE_ALL 4'h8
`define DTE_CMD_CONFIG 4'h7
`define DTE_CMD_SWAP_SELECT 4'hc
`define DTE_CMD_GLOBAL_SWAP 4'hd
`define DTE_CMD_NOP 4'hf

// Config field positions within the data word
`define DTE_CFG_OC_BIT 3
`define DTE_CFG_PL_BIT 2
`define DTE_CFG_TS_BIT 1

// Error flag register bit positions
`define DTE_FLAG_HEAT 5
`define DTE_FLAG_POWER 6
`define DTE_FLAG_LENGTH 7

// Reset values
`define DTE_SELECT_RESET 5'h00
`define DTE_GLOBAL_RESET 1'b1
`define DTE_CODE_RESET 16'h0000

`endif

/* File: inc/dte_pkg.sv */
package dte_pkg;
    typedef logic [15:0] dte_code_t;
    typedef logic [4:0] dte_chmask_t;

    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] addr;
        logic [15:0] data;
    } dte_instr_t;

    typedef struct packed {
        logic load;
        logic [4:0] mask;
        logic [4:0] from_b;
    } dte_update_t;

    typedef enum logic [1:0] {
        DTE_IDLE = 2'b00,
        DTE_SHIFT = 2'b01,
        DTE_EXEC = 2'b10
    } dte_state_t;
endpackage

/* File: logic/dte_sync.sv */
`timescale 1ns/100ps
// Two-flop synchroniser for a bundle of pin levels
module dte_sync
    import dte_pkg::*;
#(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] held;
    } dte_sync_t;

    dte_sync_t st;
    dte_sync_t next_st;

    always_comb begin
        next_st.meta = async_in;
        next_st.held = st.meta;
    end

    // No reset: pin levels ride through reset, so release shows no false edge
    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign sync_out = st.held;
endmodule

/* File: logic/dte_code_mem.sv */
`timescale 1ns/100ps
`include "dte_cfg.svh"
// Input registers A and B sharing one write port, plus the DAC registers loaded by transfer
module dte_code_mem
    import dte_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_we,
    input wire logic in_sel_b,
    input wire logic [2:0] in_ch,
    input wire dte_code_t in_code,
    input wire dte_update_t upd,
    input wire logic [2:0] rd_ch,
    output dte_code_t rd_code
);
    typedef struct packed {
        dte_code_t [4:0] reg_a;
        dte_code_t [4:0] reg_b;
        dte_code_t [4:0] dac;
        dte_code_t rd;
    } dte_mem_t;

    dte_mem_t st;
    dte_mem_t next_st;

    always_comb begin
        next_st = st;
        if (in_we && in_ch < 3'(`DTE_NUM_CH)) begin
            if (in_sel_b) begin
                next_st.reg_b[in_ch] = in_code;
            end else begin
                next_st.reg_a[in_ch] = in_code;
            end
        end
        // Transfer uses the old input values, so a same-cycle write lands next time
        for (int i = 0; i < `DTE_NUM_CH; i++) begin
            if (upd.load && upd.mask[i]) begin
                next_st.dac[i] = upd.from_b[i] ? st.reg_b[i] : st.reg_a[i];
            end
        end
        next_st.rd = (rd_ch < 3'(`DTE_NUM_CH)) ? st.dac[rd_ch] : `DTE_CODE_RESET;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_code = st.rd;
endmodule

/* File: logic/dte_core.sv */
`timescale 1ns/100ps
`include "dte_cfg.svh"
module dte_core
    import dte_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic SCK,
    input wire logic SDI,
    input wire logic SELECT_AND_LATCH_N,
    input wire logic EXTERNAL_SWAP_PIN,
    input wire logic LOAD_STROBE_PIN_N,
    input wire logic [4:0] OPEN_CIRCUIT_DETECT,
    input wire logic OVERHEAT_DETECT,
    input wire logic [4:0] POWER_LIMIT_DETECT,
    input wire logic [2:0] READ_CHANNEL,
    output logic SDO_OUT,
    output logic SDO_OE,
    output logic FAULT_OUT,
    output logic FAULT_OE,
    output logic [7:0] ERROR_FLAG_REGISTER,
    output logic [4:0] CHANNEL_SWAP_SELECT,
    output logic GLOBAL_SWAP_BIT,
    output logic [4:0] RANGE_CUT,
    output logic OVERHEAT_SHUTDOWN,
    output logic [15:0] DAC_CODE
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pins;

    dte_sync #(.W(4)) u_sync (
        .clk(CORE_CLK),
        .async_in({SCK, SDI, SELECT_AND_LATCH_N, EXTERNAL_SWAP_PIN}),
        .sync_out(pins)
    );

    logic strobe_pin;

    dte_sync #(.W(1)) u_sync_ld (
        .clk(CORE_CLK),
        .async_in(LOAD_STROBE_PIN_N),
        .sync_out(strobe_pin)
    );

    // Detector outputs come from the analog side, so they are synchronised too
    logic [10:0] cond;

    dte_sync #(.W(11)) u_sync_cond (
        .clk(CORE_CLK),
        .async_in({OPEN_CIRCUIT_DETECT, OVERHEAT_DETECT, POWER_LIMIT_DETECT}),
        .sync_out(cond)
    );

    logic [4:0] oc_s;
    logic [4:0] pl_s;
    logic oh_s;
    assign oc_s = cond[10:6];
    assign oh_s = cond[5];
    assign pl_s = cond[4:0];

    logic sck_s, sdi_s, cs_s, swp_s, ld_s;
    assign sck_s = pins[3];
    assign sdi_s = pins[2];
    assign cs_s = pins[1];
    assign swp_s = pins[0];
    assign ld_s = strobe_pin;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        dte_state_t fsm;
        logic sck_d;
        logic cs_d;
        logic swp_d;
        logic ld_d;
        logic [31:0] shreg;
        logic [15:0] count;
        logic sdo;
        dte_instr_t echo;
        logic [7:0] flags;
        logic [7:0] sticky;
        logic fault;
        dte_chmask_t sel;
        logic gbit;
        logic [2:0] cfg;
        logic we;
        logic we_b;
        logic [2:0] we_ch;
        dte_code_t we_code;
        dte_update_t upd;
    } dte_core_t;

    dte_core_t st;
    dte_core_t next_st;

    function automatic logic len_ok(input logic [15:0] n);
        len_ok = (n == 16'(`DTE_SHORT_W)) || (n != 16'h0000 && n[4:0] == 5'h00);
    endfunction

    function automatic dte_update_t swap_load(input dte_chmask_t m, input logic to_b);
        swap_load.load = 1'b1;
        swap_load.mask = m;
        swap_load.from_b = to_b ? m : 5'h00;
    endfunction

    logic sck_rise, sck_fall, cs_fall, cs_rise, swp_edge, ld_fall;
    dte_instr_t ins;
    logic [7:0] live;

    always_comb begin
        sck_rise = sck_s && !st.sck_d;
        sck_fall = !sck_s && st.sck_d;
        cs_fall = !cs_s && st.cs_d;
        cs_rise = cs_s && !st.cs_d;
        swp_edge = swp_s != st.swp_d;
        ld_fall = !ld_s && st.ld_d;
        // Short words carry 8 data bits in the high byte; the low byte is zero
        ins = (st.count == 16'(`DTE_SHORT_W)) ?
            dte_instr_t'({st.shreg[15:0], 8'h00}) : dte_instr_t'(st.shreg[23:0]);
        live = 8'h00;
        live[4:0] = st.cfg[2] ? 5'h00 : oc_s;
        live[`DTE_FLAG_HEAT] = oh_s && !st.cfg[0];
        live[`DTE_FLAG_POWER] = |pl_s && !st.cfg[1];
        next_st = st;
        next_st.sck_d = sck_s;
        next_st.cs_d = cs_s;
        next_st.swp_d = swp_s;
        next_st.ld_d = ld_s;
        next_st.we = 1'b0;
        next_st.upd = '0;
        next_st.sticky = st.sticky | live;
        if (|live) begin
            next_st.fault = 1'b1;
        end
        unique case (st.fsm)
            DTE_IDLE: begin
                if (cs_fall) begin
                    next_st.fsm = DTE_SHIFT;
                    next_st.count = '0;
                    // Load echo of last word, flag byte leading
                    next_st.shreg = {st.sticky, st.echo};
                    next_st.flags = st.sticky;
                    next_st.sticky = live;
                    next_st.sdo = st.sticky[7];
                end
            end
            DTE_SHIFT: begin
                if (sck_rise) begin
                    next_st.shreg = {st.shreg[30:0], sdi_s};
                    if (st.count != 16'hffff) begin
                        next_st.count = st.count + 16'h0001;
                    end
                end
                if (sck_fall) begin
                    next_st.sdo = st.shreg[31];
                end
                if (cs_rise) begin
                    next_st.fsm = DTE_EXEC;
                    next_st.fault = |live;
                end
            end
            DTE_EXEC: begin
                next_st.fsm = DTE_IDLE;
                if (!len_ok(st.count)) begin
                    next_st.sticky[`DTE_FLAG_LENGTH] = 1'b1;
                    next_st.fault = 1'b1;
                end else begin
                    next_st.echo = ins;
                    unique case (ins.cmd)
                        `DTE_CMD_WRITE_A_OR_B, `DTE_CMD_WRITE_UPD: begin
                            // Upper addresses would alias onto real channels
                            if (ins.addr < 4'(`DTE_NUM_CH)) begin
                                next_st.we = 1'b1;
                                next_st.we_b = st.sel[ins.addr[2:0]];
                                next_st.we_ch = ins.addr[2:0];
                                next_st.we_code = ins.data;
                            end
                        end
                        `DTE_CMD_SWAP_SELECT: begin
                            next_st.sel = ins.data[4:0];
                        end
                        `DTE_CMD_GLOBAL_SWAP: begin
                            next_st.gbit = ins.data[0];
                            if (ins.data[0] != st.gbit) begin
                                next_st.upd = swap_load(st.sel, ins.data[0]);
                            end
                        end
                        `DTE_CMD_UPDATE_ALL: begin
                            next_st.upd.load = 1'b1;
                            next_st.upd.mask = 5'h1f;
                            next_st.upd.from_b = st.sel;
                        end
                        `DTE_CMD_CONFIG: begin
                            next_st.cfg = {ins.data[`DTE_CFG_OC_BIT],
                                ins.data[`DTE_CFG_PL_BIT], ins.data[`DTE_CFG_TS_BIT]};
                        end
                        default: begin
                        end
                    endcase
                end
            end
            default: begin
                next_st.fsm = DTE_IDLE;
            end
        endcase
        // Pin events; serial command wins when both fall in one cycle
        if (!next_st.upd.load) begin
            if (swp_edge) begin
                next_st.upd = swap_load(st.sel, swp_s);
            end else if (ld_fall) begin
                next_st.upd.load = 1'b1;
                next_st.upd.mask = 5'h1f;
                next_st.upd.from_b = st.sel;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            st <= '0;
            // Edge memories follow the pins so release makes no false edge
            st.sck_d <= sck_s;
            st.cs_d <= cs_s;
            st.swp_d <= swp_s;
            st.ld_d <= ld_s;
            st.sel <= `DTE_SELECT_RESET;
            st.gbit <= `DTE_GLOBAL_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Code storage
    // ------------------------------------------------------------
    dte_code_mem u_mem (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .in_we(st.we),
        .in_sel_b(st.we_b),
        .in_ch(st.we_ch),
        .in_code(st.we_code),
        .upd(st.upd),
        .rd_ch(READ_CHANNEL),
        .rd_code(DAC_CODE)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign SDO_OUT = st.sdo;
    assign SDO_OE = (st.fsm == DTE_SHIFT);
    assign FAULT_OUT = 1'b0;
    assign FAULT_OE = st.fault;
    assign ERROR_FLAG_REGISTER = st.flags;
    assign CHANNEL_SWAP_SELECT = st.sel;
    assign GLOBAL_SWAP_BIT = st.gbit;
    assign RANGE_CUT = st.cfg[1] ? 5'h00 : pl_s;
    assign OVERHEAT_SHUTDOWN = oh_s && !st.cfg[0];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_latch_rise;
        st.fsm == DTE_SHIFT && cs_rise;
    endsequence

    sequence s_exec_ok;
        st.fsm == DTE_EXEC && len_ok(st.count);
    endsequence

    a_sdo_release: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        s_latch_rise |=> !SDO_OE ##1 !SDO_OE) else $error("serial out held after latch");
    a_select_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        next_st.we |-> next_st.we_b == st.sel[next_st.we_ch]) else $error("bad target");
    a_fault_release: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        s_latch_rise and (live == 8'h00) |=> !FAULT_OE) else $error("fault held");
    a_len_flag: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        st.fsm == DTE_EXEC && !len_ok(st.count) |=> st.sticky[7] && !st.we)
        else $error("bad length not flagged");
    a_no_static: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $stable(swp_s) && !ld_fall && st.fsm != DTE_EXEC |=> !st.upd.load)
        else $error("update without edge");
    a_pin_rise_b: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $rose(swp_s) && st.fsm != DTE_EXEC |=> st.upd.from_b == $past(st.sel))
        else $error("rise not from B");
    a_echo_load: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        st.fsm == DTE_IDLE && cs_fall |=> st.shreg[31:24] == $past(st.sticky)
        && st.sdo == $past(st.sticky[7])) else $error("flag byte not leading");
    a_shift_in: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        st.fsm == DTE_SHIFT && sck_rise |=> st.shreg[0] == $past(sdi_s))
        else $error("serial input not sampled");
    a_update_all: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        s_exec_ok ##0 (ins.cmd == `DTE_CMD_UPDATE_ALL) |=> st.upd.load
        && st.upd.mask == 5'h1f && st.upd.from_b == $past(st.sel))
        else $error("update all source wrong");
    a_global_fall: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        s_exec_ok ##0 (ins.cmd == `DTE_CMD_GLOBAL_SWAP && !ins.data[0] && st.gbit)
        |=> st.upd.load && st.upd.from_b == 5'h00) else $error("global fall not from A");
endmodule

/* File: sim/dte_host.sv */
`timescale 1ns/100ps
module dte_host (
    input wire logic clk,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    output logic sck,
    output logic sdi,
    output logic cs_n
);
    logic line;
    // Pull-up holds the shared line high once released
    assign line = sdo_oe ? sdo_out : 1'b1;
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        cs_n = 1'b1;
    end
    // ----------------
    // Frame, MSB first, SCK idle low
    // ----------------
    task automatic xfer(input int n, input logic [63:0] w, output logic [63:0] e);
        e = '0;
        repeat (4) @(negedge clk);
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            repeat (4) @(negedge clk);
            sck = 1'b1;
            e = {e[62:0], line};
            repeat (4) @(negedge clk);
            sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        // No stale data bit left behind
        sdi = ~sdi;
        repeat (12) @(negedge clk);
    endtask
endmodule

/* File: sim/tb.sv */
`timescale 1ns/100ps
module tb
    import dte_pkg::*;
;
    logic clk, rst_n, sck, sdi, cs_n, pin, strobe_n, oh, sdo_out, sdo_oe;
    logic fault_out, fault_oe, gbit_o, shut, g, bad;
    logic [4:0] oc, pl, sel_o, cut, sel;
    logic [2:0] rch, cfg;
    logic [7:0] efr, last_live;
    logic [23:0] prev;
    dte_code_t dac_o;
    dte_code_t ra [5], rb [5], dac [5];
    int bad_count, checks_done;

    dte_core dte_core_i (
        .CORE_CLK(clk),
        .RST_N(rst_n),
        .SCK(sck),
        .SDI(sdi),
        .SELECT_AND_LATCH_N(cs_n),
        .EXTERNAL_SWAP_PIN(pin),
        .LOAD_STROBE_PIN_N(strobe_n),
        .OPEN_CIRCUIT_DETECT(oc),
        .OVERHEAT_DETECT(oh),
        .POWER_LIMIT_DETECT(pl),
        .READ_CHANNEL(rch),
        .SDO_OUT(sdo_out),
        .SDO_OE(sdo_oe),
        .FAULT_OUT(fault_out),
        .FAULT_OE(fault_oe),
        .ERROR_FLAG_REGISTER(efr),
        .CHANNEL_SWAP_SELECT(sel_o),
        .GLOBAL_SWAP_BIT(gbit_o),
        .RANGE_CUT(cut),
        .OVERHEAT_SHUTDOWN(shut),
        .DAC_CODE(dac_o)
    );
    dte_host dte_host_i (
        .clk(clk),
        .sdo_out(sdo_out),
        .sdo_oe(sdo_oe),
        .sck(sck),
        .sdi(sdi),
        .cs_n(cs_n)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ----------------
    // Reporting
    // ----------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------
    // Reference model
    // ----------------
    function automatic logic [7:0] live();
        live = {1'b0, (|pl) & ~cfg[1], oh & ~cfg[0], oc & ~{5{cfg[2]}}};
    endfunction
    task automatic upd_all();
        for (int i = 0; i < 5; i++) dac[i] = sel[i] ? rb[i] : ra[i];
    endtask
    task automatic check_dac();
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            rch = 3'(i);
            repeat (3) @(negedge clk);
            check(dac_o, dac[i]);
        end
        check(sel_o, sel);
        check(gbit_o, g);
        check(sdo_oe, 1'b0);
    endtask
    task automatic run(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
        case (c)
            4'h0, 4'h3: if (a < 5) begin
                if (sel[a]) rb[a] = d;
                else ra[a] = d;
            end
            4'h7: cfg = d[3:1];
            4'h9: upd_all();
            4'hc: sel = d[4:0];
            4'hd: if (d[0] != g) begin
                g = d[0];
                for (int i = 0; i < 5; i++) if (sel[i]) dac[i] = g ? rb[i] : ra[i];
            end
            default: ;
        endcase
    endtask
    task automatic send(input int n, input logic [3:0] c, input logic [3:0] a,
                        input logic [15:0] d);
        logic [63:0] w;
        logic [63:0] e;
        logic [31:0] x;
        logic [7:0] lv;
        lv = live();
        x = {lv | last_live | {bad, 7'h00}, prev};
        last_live = lv;
        // Downstream device gets a no-op
        w = {8'h00, 4'hf, 4'h0, 16'h0000, 8'h00, c, a, d};
        if (n == 24) w = {40'h0, c, a, d[15:8]};
        if (n == 20) w = {44'h0, c, a, d[15:4]};
        dte_host_i.xfer(n, w, e);
        if (n >= 32) check(e[n-1 -: 32], x);
        else check(e & ((64'h1 << n) - 1), x >> (32 - n));
        if (n == 64) check(e[31:0], w[63:32]);
        check(efr, x[31:24]);
        bad = (n == 20);
        if (n == 24) d[7:0] = 8'h00;
        if (!bad) begin
            prev = {c, a, d};
            run(c, a, d);
        end
        check_dac();
    endtask
    task automatic strobe();
        @(negedge clk);
        strobe_n = 1'b0;
        repeat (4) @(negedge clk);
        strobe_n = 1'b1;
        repeat (6) @(negedge clk);
        upd_all();
        check_dac();
    endtask
    task automatic pin_to(input logic v);
        @(negedge clk);
        pin = v;
        repeat (8) @(negedge clk);
        for (int i = 0; i < 5; i++) if (sel[i]) dac[i] = v ? rb[i] : ra[i];
        check_dac();
    endtask
    // ----------------
    // Stimulus
    // ----------------
    initial begin
        #2ms;
        bad_count++;
        results();
    end
    initial begin
        rst_n = 1'b0;
        pin = 1'b1;
        strobe_n = 1'b1;
        {oh, oc, pl, rch, sel, cfg, bad, prev, last_live} = '0;
        g = 1'b1;
        bad_count = 0;
        checks_done = 0;
        for (int i = 0; i < 5; i++) {ra[i], rb[i], dac[i]} = '0;
        void'($urandom(18870));
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check_dac();
        for (int i = 0; i < 5; i++) send(32, 4'h0, 4'(i), 16'($urandom));
        send(32, 4'h9, 4'h0, 16'h0000);
        send(32, 4'hc, 4'h0, 16'h001f);
        for (int i = 0; i < 5; i++) send(32, 4'h0, 4'(i), 16'($urandom));
        send(32, 4'hd, 4'h0, 16'h0001);
        send(32, 4'hd, 4'h0, 16'h0000);
        send(32, 4'hd, 4'h0, 16'h0000);
        send(32, 4'hd, 4'h0, 16'h0001);
        send(32, 4'hc, 4'h0, 16'h0000);
        send(32, 4'h3, 4'h3, 16'hffff);
        send(32, 4'hc, 4'h0, 16'h0008);
        strobe();
        for (int r = 0; r < 8; r++) begin
            send(32, 4'hc, 4'h0, 16'($urandom));
            send(32, 4'h0, 4'($urandom_range(4)), 16'($urandom));
            case (r % 4)
                0: send(32, 4'h9, 4'h0, 16'h0000);
                1: strobe();
                2: begin
                    send(32, 4'hd, 4'h0, 16'h0000);
                    send(32, 4'hd, 4'h0, 16'h0001);
                end
                default: begin
                    pin_to(1'b0);
                    pin_to(1'b1);
                end
            endcase
        end
        send(24, 4'h3, 4'h4, 16'($urandom));
        send(20, 4'hc, 4'h0, 16'hffff);
        check(fault_oe, 1'b1);
        send(64, 4'h0, 4'h7, 16'h1234);
        send(32, 4'hf, 4'h0, 16'h0000);
        oc = 5'($urandom) | 5'h01;
        pl = 5'($urandom) | 5'h10;
        oh = 1'b1;
        send(32, 4'hf, 4'h0, 16'h0000);
        check(fault_oe, 1'b1);
        check(fault_out, 1'b0);
        check(cut, pl);
        check(shut, 1'b1);
        send(32, 4'h7, 4'h0, 16'h000e);
        check(cut, 5'h00);
        check(shut, 1'b0);
        {oh, oc, pl} = '0;
        send(32, 4'hf, 4'h0, 16'h0000);
        send(32, 4'h7, 4'h0, 16'h0000);
        check(fault_oe, 1'b0);
        results();
    end
endmodule
